// ==== verilog/stb_pkg.sv ====
package stb_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [9:0] STB_IDX_TIMING_A = 10'h31A;
  localparam logic [9:0] STB_IDX_TIMING_B = 10'h31B;
  localparam logic [9:0] STB_IDX_OFF_DUAL_FIRST = 10'h344;
  localparam logic [9:0] STB_IDX_OFF_DUAL_SECOND = 10'h346;
  localparam logic [9:0] STB_IDX_OFF_SINGLE_FIRST = 10'h348;
  localparam logic [9:0] STB_IDX_CONTROL = 10'h360;
  localparam logic [9:0] STB_IDX_STATUS = 10'h361;
  // Field widths and positions
  localparam int STB_TW = 8;
  localparam int STB_OW = 12;
  localparam int STB_RW = 16;
  localparam int STB_CTL_SINGLE = 0;
  localparam int STB_CTL_SECOND = 1;
  localparam int STB_CTL_FGCAL = 2;
  localparam int STB_CTL_RELOAD = 3;
  localparam int STB_ST_LOADED = 3;
  // Reset values before the fuse load lands
  localparam logic [STB_TW-1:0] STB_TIMING_RST = 8'h00;
  localparam logic [STB_RW-1:0] STB_OFFSET_RST = 16'h0000;
  localparam logic [31:0] STB_ZERO_WORD = 32'h00000000;
  // Fuse load sequencer
  typedef enum logic [1:0] {
    STB_LOAD = 2'b01,
    STB_RUN = 2'b10
  } stb_state_type;
endpackage : stb_pkg

// ==== verilog/stb_trim_if.sv ====
`timescale 1ns/100ps
interface stb_trim_if;
  import stb_pkg::*;
  // Stored trims and operating mode
  logic [STB_TW-1:0] timing_a;
  logic [STB_TW-1:0] timing_b;
  logic [STB_RW-1:0] off_dual_first;
  logic [STB_RW-1:0] off_dual_second;
  logic [STB_RW-1:0] off_single_first;
  logic single_mode;
  logic second_input;
  logic fg_cal_en;
  // Selected trims
  logic [STB_TW-1:0] sel_timing_a;
  logic [STB_TW-1:0] sel_timing_b;
  logic [STB_OW-1:0] sel_offset_a;
  logic timing_used;
  logic offset_used;
  modport regs (output timing_a, timing_b, off_dual_first, off_dual_second, off_single_first,
    single_mode, second_input, fg_cal_en,
    input sel_timing_a, sel_timing_b, sel_offset_a, timing_used, offset_used);
  modport sel (input timing_a, timing_b, off_dual_first, off_dual_second, off_single_first,
    single_mode, second_input, fg_cal_en,
    output sel_timing_a, sel_timing_b, sel_offset_a, timing_used, offset_used);
endinterface : stb_trim_if

// ==== verilog/stb_trim_select.sv ====
`timescale 1ns/100ps
module stb_trim_select
  import stb_pkg::*;
(
  // Stored trims in, selection out
  stb_trim_if.sel trim
);
  // Timing trims of this bank only cover single-channel, calibrated, second input
  always_comb begin
    trim.timing_used = trim.single_mode && trim.fg_cal_en && trim.second_input;
    trim.sel_timing_a = trim.timing_used ? trim.timing_a : STB_TIMING_RST;
    trim.sel_timing_b = trim.timing_used ? trim.timing_b : STB_TIMING_RST;
  end

  // Offset for core A; only bits 11:0 reach the core
  always_comb begin
    trim.offset_used = 1'b0;
    trim.sel_offset_a = STB_OFFSET_RST[STB_OW-1:0];
    if (trim.fg_cal_en) begin
      if (!trim.single_mode && !trim.second_input) begin
        trim.offset_used = 1'b1;
        trim.sel_offset_a = trim.off_dual_first[STB_OW-1:0];
      end else if (!trim.single_mode) begin
        trim.offset_used = 1'b1;
        trim.sel_offset_a = trim.off_dual_second[STB_OW-1:0];
      end else if (!trim.second_input) begin
        trim.offset_used = 1'b1;
        trim.sel_offset_a = trim.off_single_first[STB_OW-1:0];
      end
    end
  end
endmodule : stb_trim_select

// ==== verilog/stb_trim_bank.sv ====
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module stb_trim_bank
  import stb_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fuse storage defaults
  input wire logic [STB_TW-1:0] fuse_timing_a,
  input wire logic [STB_TW-1:0] fuse_timing_b,
  input wire logic [STB_OW-1:0] fuse_off_dual_first,
  input wire logic [STB_OW-1:0] fuse_off_dual_second,
  input wire logic [STB_OW-1:0] fuse_off_single_first,
  // Trims toward the converter cores
  output logic [STB_TW-1:0] core_a_timing,
  output logic [STB_TW-1:0] core_b_timing,
  output logic [STB_OW-1:0] core_a_offset,
  output logic timing_applied,
  output logic offset_applied
);
  stb_trim_if trim ();
  stb_state_type state;
  logic [31:0] ctrl_word;
  logic reload;
  logic setup;
  logic access;
  logic wr;
  logic [9:0] idx;

  // Merge one write with byte strobes into a stored value
  function automatic logic [STB_RW-1:0] merge16(input logic [STB_RW-1:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) merge16[7:0] = data[7:0];
    if (strb[1]) merge16[15:8] = data[15:8];
  endfunction : merge16

  // Address is word aligned; low two bits ignored
  function automatic logic mapped(input logic [9:0] i);
    mapped = (i == STB_IDX_TIMING_A) || (i == STB_IDX_TIMING_B) ||
             (i == STB_IDX_OFF_DUAL_FIRST) || (i == STB_IDX_OFF_DUAL_SECOND) ||
             (i == STB_IDX_OFF_SINGLE_FIRST) || (i == STB_IDX_CONTROL) ||
             (i == STB_IDX_STATUS);
  endfunction : mapped

  // Bus phases; a frozen clock enable stretches the access
  assign idx = paddr[11:2];
  assign setup = psel && !penable && pclk_en;
  assign access = psel && penable && pclk_en;
  assign wr = access && pwrite && !pslverr;
  assign pready = pclk_en;
  assign pslverr = psel && penable && !mapped(idx);
  assign reload = wr && (idx == STB_IDX_CONTROL) && pstrb[0] && pwdata[STB_CTL_RELOAD];

  // Fuse load after reset release, again on a reload request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= STB_LOAD;
    end else if (pclk_en) begin
      case (state)
        STB_LOAD: state <= STB_RUN;
        STB_RUN: state <= reload ? STB_LOAD : STB_RUN;
        default: state <= STB_LOAD;
      endcase
    end
  end

  // Timing trims: fuse default, then software may override
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim.timing_a <= STB_TIMING_RST;
      trim.timing_b <= STB_TIMING_RST;
    end else if (pclk_en) begin
      if (state == STB_LOAD) begin
        trim.timing_a <= fuse_timing_a;
        trim.timing_b <= fuse_timing_b;
      end else if (wr && pstrb[0]) begin
        if (idx == STB_IDX_TIMING_A) trim.timing_a <= pwdata[STB_TW-1:0];
        if (idx == STB_IDX_TIMING_B) trim.timing_b <= pwdata[STB_TW-1:0];
      end
    end
  end

  // Offset trims; reserved bits store but never reach a core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim.off_dual_first <= STB_OFFSET_RST;
      trim.off_dual_second <= STB_OFFSET_RST;
      trim.off_single_first <= STB_OFFSET_RST;
    end else if (pclk_en) begin
      if (state == STB_LOAD) begin
        trim.off_dual_first <= {4'h0, fuse_off_dual_first};
        trim.off_dual_second <= {4'h0, fuse_off_dual_second};
        trim.off_single_first <= {4'h0, fuse_off_single_first};
      end else if (wr) begin
        if (idx == STB_IDX_OFF_DUAL_FIRST)
          trim.off_dual_first <= merge16(trim.off_dual_first, pwdata, pstrb);
        if (idx == STB_IDX_OFF_DUAL_SECOND)
          trim.off_dual_second <= merge16(trim.off_dual_second, pwdata, pstrb);
        if (idx == STB_IDX_OFF_SINGLE_FIRST)
          trim.off_single_first <= merge16(trim.off_single_first, pwdata, pstrb);
      end
    end
  end

  // Operating mode control; reload bit is a write pulse only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim.single_mode <= 1'b0;
      trim.second_input <= 1'b0;
      trim.fg_cal_en <= 1'b0;
    end else if (pclk_en && wr && pstrb[0] && idx == STB_IDX_CONTROL) begin
      trim.single_mode <= pwdata[STB_CTL_SINGLE];
      trim.second_input <= pwdata[STB_CTL_SECOND];
      trim.fg_cal_en <= pwdata[STB_CTL_FGCAL];
    end
  end

  stb_trim_select u_select (
    .trim(trim)
  );

  // Applied trims are registered so the cores see glitch-free values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_a_timing <= STB_TIMING_RST;
      core_b_timing <= STB_TIMING_RST;
      core_a_offset <= STB_OFFSET_RST[STB_OW-1:0];
      timing_applied <= 1'b0;
      offset_applied <= 1'b0;
    end else if (pclk_en) begin
      core_a_timing <= trim.sel_timing_a;
      core_b_timing <= trim.sel_timing_b;
      core_a_offset <= trim.sel_offset_a;
      timing_applied <= trim.timing_used;
      offset_applied <= trim.offset_used;
    end
  end

  // Read data captured in the setup phase, held through the access
  always_comb begin
    ctrl_word = STB_ZERO_WORD;
    ctrl_word[STB_CTL_SINGLE] = trim.single_mode;
    ctrl_word[STB_CTL_SECOND] = trim.second_input;
    ctrl_word[STB_CTL_FGCAL] = trim.fg_cal_en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= STB_ZERO_WORD;
    end else if (setup) begin
      case (idx)
        STB_IDX_TIMING_A: prdata <= {24'h000000, trim.timing_a};
        STB_IDX_TIMING_B: prdata <= {24'h000000, trim.timing_b};
        STB_IDX_OFF_DUAL_FIRST: prdata <= {16'h0000, trim.off_dual_first};
        STB_IDX_OFF_DUAL_SECOND: prdata <= {16'h0000, trim.off_dual_second};
        STB_IDX_OFF_SINGLE_FIRST: prdata <= {16'h0000, trim.off_single_first};
        STB_IDX_CONTROL: prdata <= ctrl_word;
        STB_IDX_STATUS: prdata <= {28'h0000000, (state == STB_RUN), 1'b0,
                                   trim.offset_used, trim.timing_used};
        default: prdata <= STB_ZERO_WORD;
      endcase
    end
  end

  // Checks; the load check also needs reset released, so the last reset edge is not a load
  chk_fuse_load: assert property (@(posedge pclk) disable iff (!presetn)
    (presetn && pclk_en && state == STB_LOAD) |=> (trim.timing_a == $past(fuse_timing_a)))
    else $error("timing trim not loaded from fuse");
  chk_write_takes: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && state == STB_RUN && pstrb[0] && idx == STB_IDX_TIMING_B)
      |=> (trim.timing_b == $past(pwdata[STB_TW-1:0])))
    else $error("timing write lost");
  chk_timing_a_sel: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && trim.single_mode && trim.fg_cal_en && trim.second_input)
      |=> (core_a_timing == $past(trim.timing_a)) && timing_applied)
    else $error("core A timing not applied");
  chk_timing_b_sel: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && trim.timing_used) |=> (core_b_timing == $past(trim.timing_b)))
    else $error("core B timing not applied");
  chk_dual_first: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && !trim.single_mode && trim.fg_cal_en && !trim.second_input)
      |=> (core_a_offset == $past(trim.off_dual_first[STB_OW-1:0])))
    else $error("dual first offset wrong");
  chk_dual_second: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && !trim.single_mode && trim.fg_cal_en && trim.second_input)
      |=> (core_a_offset == $past(trim.off_dual_second[STB_OW-1:0])))
    else $error("dual second offset wrong");
  chk_single_first: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && trim.single_mode && trim.fg_cal_en && !trim.second_input)
      |=> (core_a_offset == $past(trim.off_single_first[STB_OW-1:0])) && offset_applied)
    else $error("single first offset wrong");
  chk_no_cal_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && !trim.fg_cal_en) |=> !timing_applied && !offset_applied)
    else $error("trim applied without calibration");
  chk_timing_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!pclk_en) |=> $stable(core_a_timing) && $stable(core_b_timing))
    else $error("timing moved while frozen");
endmodule : stb_trim_bank

// ==== sim/stb_trim_bank_bench.sv ====
`timescale 1ns/100ps
module stb_trim_bank_bench;
  import stb_pkg::*;
  // Clock, reset and bus drive
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic pclk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, timing_applied, offset_applied;
  // Fuse storage defaults, distinct so a swapped register shows up
  logic [7:0] fa = 8'h5A;
  logic [7:0] fb = 8'hC3;
  logic [11:0] fo1 = 12'h9E1;
  logic [11:0] fo2 = 12'h4B7;
  logic [11:0] fo3 = 12'h2D6;
  logic [7:0] core_a_timing, core_b_timing;
  logic [11:0] core_a_offset;
  int n_errors = 0;
  int n_checks = 0;
  logic [15:0] sh [5];
  logic [11:0] ad [5];
  localparam logic [11:0] CTL = {STB_IDX_CONTROL, 2'b00};
  localparam logic [11:0] STA = {STB_IDX_STATUS, 2'b00};

  always #5 pclk = ~pclk;

  stb_trim_bank dut (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fuse_timing_a(fa),
    .fuse_timing_b(fb), .fuse_off_dual_first(fo1), .fuse_off_dual_second(fo2),
    .fuse_off_single_first(fo3), .core_a_timing(core_a_timing),
    .core_b_timing(core_b_timing), .core_a_offset(core_a_offset),
    .timing_applied(timing_applied), .offset_applied(offset_applied));

  // Single compare point, counts every check
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; waits on pready under a bound instead of assuming zero wait
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
           output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, s, r, e);
  endtask : wr

  task rd(input string what, input logic [11:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, 4'h0, r, e);
    chk(what, exp, r);
    chk("pslverr", {31'b0, ee}, {31'b0, e});
  endtask : rd

  // Output checks one edge after the change has landed
  task outs(input logic [2:0] m);
    logic ton, oon;
    logic [11:0] eo;
    logic [7:0] ea, eb;
    ton = m[0] & m[1] & m[2];
    oon = m[2] & !(m[0] & m[1]);
    eo = !oon ? 12'h000 : (m[0] ? sh[4][11:0] : (m[1] ? sh[3][11:0] : sh[2][11:0]));
    ea = ton ? sh[0][7:0] : 8'h00;
    eb = ton ? sh[1][7:0] : 8'h00;
    #1;
    chk("core_a_timing", {24'b0, ea}, {24'b0, core_a_timing});
    chk("core_b_timing", {24'b0, eb}, {24'b0, core_b_timing});
    chk("core_a_offset", {20'b0, eo}, {20'b0, core_a_offset});
    chk("applied flags", {30'b0, oon, ton}, {30'b0, offset_applied, timing_applied});
    @(posedge pclk);
    rd("status", STA, {28'h0, 2'b10, oon, ton}, 1'b0);
  endtask : outs

  task results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // Tests run under two hundred cycles; this bound is generous
  initial begin
    #40000;
    n_errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    results;
  end

  initial begin
    ad = '{{STB_IDX_TIMING_A, 2'b00}, {STB_IDX_TIMING_B, 2'b00},
      {STB_IDX_OFF_DUAL_FIRST, 2'b00}, {STB_IDX_OFF_DUAL_SECOND, 2'b00},
      {STB_IDX_OFF_SINGLE_FIRST, 2'b00}};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    sh = '{{8'h00, fa}, {8'h00, fb}, {4'h0, fo1}, {4'h0, fo2}, {4'h0, fo3}};
    for (int i = 0; i < 5; i++) rd("fuse default", ad[i], {16'h0, sh[i]}, 1'b0);
    rd("status", STA, 32'h00000008, 1'b0);
    $display("test fuse_defaults done");
    // Overwrite with upper junk: timing keeps 8 bits, offsets keep 16 incl. reserved
    sh = '{16'h00A5, 16'h003C, 16'hF123, 16'h8ABC, 16'h7FED};
    for (int i = 0; i < 5; i++) wr(ad[i], {16'hFFFF, sh[i] | (i < 2 ? 16'hFF00 : 16'h0)}, 4'hF);
    for (int i = 0; i < 5; i++) rd("readback", ad[i], {16'h0, sh[i]}, 1'b0);
    wr(ad[2], 32'h00005566, 4'b0001);
    sh[2][7:0] = 8'h66;
    rd("lane 0 only", ad[2], {16'h0, sh[2]}, 1'b0);
    $display("test readback done");
    for (int m = 0; m < 8; m++) begin
      wr(CTL, {29'b0, m[2:0]}, 4'hF);
      outs(m[2:0]);
    end
    $display("test mode_select done");
    // Clock enable low: the access stalls and nothing moves until it returns
    pclk_en <= 1'b0;
    fork
      wr(ad[0], 32'h0000005B, 4'hF);
      begin
        repeat (4) @(posedge pclk);
        chk("pready frozen", 32'h00000000, {31'b0, pready});
        chk("frozen timing", {24'b0, sh[0][7:0]}, {24'b0, core_a_timing});
        pclk_en <= 1'b1;
      end
    join
    rd("frozen write", ad[0], 32'h0000005B, 1'b0);
    $display("test freeze done");
    rd("unmapped", 12'h000, 32'h00000000, 1'b1);
    wr(STA, 32'h00000000, 4'hF);
    rd("status after write", STA, 32'h00000009, 1'b0);
    $display("test refusals done");
    // Fresh fuse contents prove reload copies fuses, not a constant
    fa <= 8'h17;
    fb <= 8'hE8;
    fo1 <= 12'h3C5;
    fo2 <= 12'hA0F;
    fo3 <= 12'h6B2;
    wr(CTL, 32'h0000000C, 4'hF);
    // Fuse copy lands one edge after the reload write; cores follow one edge later
    @(posedge pclk);
    sh = '{16'h0017, 16'h00E8, 16'h03C5, 16'h0A0F, 16'h06B2};
    outs(3'b100);
    for (int i = 0; i < 5; i++) rd("reloaded", ad[i], {16'h0, sh[i]}, 1'b0);
    $display("test reload done");
    results;
  end
endmodule : stb_trim_bank_bench
